// ---- hdl/tcp_channel.sv ----
// continuous pulse output timer channel: 16-bit down-counter with reload and toggling output
`timescale 1ns/1ps
module tcp_channel
   import tcp_pkg::*;
(
   // clock and reset
   input  wire logic             i_clock,
   input  wire logic             i_resetn,
   // software side
   input  wire tcp_sw_s          i_sw,
   // pins: count clock and external enable, both asynchronous
   input  wire logic             i_count_clk,
   input  wire logic             i_ext_enable,
   // status and outputs
   output logic [CNT_W-1:0]      o_count,
   output logic [CNT_W-1:0]      o_reload,
   output logic                  o_running,
   output logic                  o_inout_timer_channel,
   output logic                  o_irq
);

   tcp_state_s s_q;
   tcp_state_s s_d;

   logic cclk_s;
   logic cclk_prev_q;
   logic ext_s;
   logic ext_prev_q;
   logic tick;
   logic ext_rise;
   logic uflow;

   // both pins cross into the system clock before any logic sees them
   tcp_sync u_sync_cclk
   (
      .i_clock  (i_clock),
      .i_resetn (i_resetn),
      .i_async  (i_count_clk),
      .o_sync   (cclk_s)
   );

   tcp_sync u_sync_ext
   (
      .i_clock  (i_clock),
      .i_resetn (i_resetn),
      .i_async  (i_ext_enable),
      .o_sync   (ext_s)
   );

   // edge history of the synchronised pins
   always_ff @(posedge i_clock or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         cclk_prev_q <= 1'h0;
         ext_prev_q  <= 1'h0;
      end
      else
      begin
         cclk_prev_q <= cclk_s;
         ext_prev_q  <= ext_s;
      end
   end

   // a count clock is a rising edge of the pin; the enable acts on its rising edge
   assign tick     = cclk_s & ~cclk_prev_q;
   assign ext_rise = ext_s & ~ext_prev_q;

   // underflow: decrement while holding zero
   assign uflow = s_q.run & tick & (s_q.cnt == CNT_RST);

   // next-state logic
   always_comb
   begin
      s_d          = s_q;
      s_d.irq      = 1'h0;
      s_d.uflow_q  = 1'h0;
      s_d.run_prev = s_q.run;

      // register writes; reload value is held in a 16-bit register
      if (i_sw.rld_wr)
      begin
         s_d.rld = i_sw.rld_data;
      end
      if (i_sw.cnt_wr && !s_q.run)
      begin
         s_d.cnt = i_sw.cnt_data;
      end

      // counting: continuous mode never stops itself, so the underflow stop
      // term is always clear; the priority chain is kept for the enable pin
      if (s_q.run && tick)
      begin
         if (uflow)
         begin
            s_d.cnt     = s_q.rld;
            s_d.ff      = ~s_q.ff;
            s_d.irq     = 1'h1;
            s_d.uflow_q = 1'h1;
         end
         else
         begin
            s_d.cnt = s_q.cnt - CNT_ONE;
         end
      end

      // enable control: software write wins over everything
      if (i_sw.en_wr)
      begin
         s_d.run = i_sw.en_data;
      end
      else if (ext_rise && !s_q.run)
      begin
         s_d.run = 1'h1;
      end

      // output toggles when counting starts
      if (s_d.run && !s_q.run)
      begin
         s_d.ff = ~s_q.ff;
      end
   end

   // state register
   always_ff @(posedge i_clock or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // the count is output as held: it reloads at zero, so the read after an underflow is the reload value, not a wrap to all ones
   assign o_count               = s_q.cnt;
   assign o_reload              = s_q.rld;
   assign o_running             = s_q.run;
   assign o_inout_timer_channel = s_q.ff;
   assign o_irq                 = s_q.irq;

endmodule : tcp_channel

// ---- hdl/tcp_pkg.sv ----
// package for the continuous pulse output timer channel
package tcp_pkg;

   // counter and reload width
   localparam int CNT_W = 16;

   // reset values and counter constants
   localparam logic [CNT_W-1:0] CNT_RST  = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_ONES = 16'hFFFF;
   localparam logic [CNT_W-1:0] CNT_ONE  = 16'h0001;
   localparam logic             OUT_RST  = 1'h0;

   // software write port into the channel
   typedef struct packed {
      logic             cnt_wr;    // load counter starting value
      logic [CNT_W-1:0] cnt_data;
      logic             rld_wr;    // load reload-0 register
      logic [CNT_W-1:0] rld_data;
      logic             en_wr;     // write to count enable bit
      logic             en_data;
   } tcp_sw_s;

   // channel state
   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic [CNT_W-1:0] rld;
      logic             run;
      logic             ff;
      logic             irq;
      logic             uflow_q;   // set at the same edge as the reload, alongside irq
      logic             run_prev;
   } tcp_state_s;

endpackage : tcp_pkg

// ---- hdl/tcp_sync.sv ----
// two flip-flop synchroniser for the external enable and count clock pins
`timescale 1ns/1ps
module tcp_sync
   import tcp_pkg::*;
(
   // clock and reset
   input  wire logic i_clock,
   input  wire logic i_resetn,
   // asynchronous level in, synchronised level out
   input  wire logic i_async,
   output logic      o_sync
);

   logic meta_q;

   // first stage feeds only the second stage
   always_ff @(posedge i_clock or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         meta_q <= 1'h0;
         o_sync <= 1'h0;
      end
      else
      begin
         meta_q <= i_async;
         o_sync <= meta_q;
      end
   end

endmodule : tcp_sync

// ---- sim/tcp_far.sv ----
// count clock pin driver standing in for the far side
`timescale 1ns/1ps
module tcp_far (
   input  wire logic i_clock,
   input  wire logic i_go,
   output logic      o_clk = 1'h0,
   output logic [7:0] o_edges = 8'h00
);
   logic [2:0] div_q = 3'h0;
   // 8-clock period so the synchroniser sees every level; idles low
   always @(posedge i_clock)
   begin
      div_q <= i_go ? div_q + 3'h1 : 3'h0;
      o_clk <= i_go & div_q[2];
      if (i_go && div_q == 3'h3) o_edges <= o_edges + 8'h01;
   end
endmodule : tcp_far

// ---- sim/tcp_channel_assertions.sv ----
// concurrent checks on the channel ports
`timescale 1ns/1ps
module tcp_channel_assertions
   import tcp_pkg::*;
(
   input wire logic             i_clock,
   input wire logic             i_resetn,
   input wire tcp_sw_s          i_sw,
   input wire logic             i_count_clk,
   input wire logic             i_ext_enable,
   input wire logic [CNT_W-1:0] o_count,
   input wire logic [CNT_W-1:0] o_reload,
   input wire logic             o_running,
   input wire logic             o_inout_timer_channel,
   input wire logic             o_irq
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_resetn);
   sequence s_on;  i_sw.en_wr && i_sw.en_data;  endsequence
   sequence s_off; i_sw.en_wr && !i_sw.en_data; endsequence
   AST_IRQ_PULSE: assert property (o_irq |=> !o_irq)
      else $error("irq too long");
   AST_IRQ_TOGGLE: assert property (o_irq |-> $changed(o_inout_timer_channel))
      else $error("no toggle at underflow");
   AST_START_TOGGLE: assert property ($rose(o_running) |-> $changed(o_inout_timer_channel))
      else $error("no toggle at start");
   AST_RELOAD: assert property (o_irq |-> o_count == o_reload)
      else $error("no reload");
   AST_FROM_ZERO: assert property (o_irq |-> $past(o_count) == CNT_RST && $past(o_running))
      else $error("underflow not from zero");
   AST_SW_ON: assert property (s_on |=> o_running)
      else $error("enable ignored");
   AST_SW_OFF: assert property (s_off |=> !o_running)
      else $error("stop ignored");
   AST_STOP_CAUSE: assert property ($fell(o_running) |-> $past(i_sw.en_wr && !i_sw.en_data))
      else $error("stopped by itself");
endmodule : tcp_channel_assertions
bind tcp_channel tcp_channel_assertions u_tcp_channel_assertions (.*);

// ---- sim/tb_tcp_channel.sv ----
// testbench for the continuous pulse output channel
`timescale 1ns/1ps
module tb_tcp_channel
   import tcp_pkg::*;
;
   logic i_clock = 1'h0, i_resetn = 1'h0, i_ext_enable = 1'h0, go = 1'h0;
   logic i_count_clk, o_running, o_inout_timer_channel, o_irq, f;
   logic [CNT_W-1:0] o_count, o_reload;
   logic [7:0] edges, e0, n;
   tcp_sw_s i_sw = '0;
   int mismatches = 0, checks = 0, cyc = 0;
   tcp_channel u_tcp_channel (.*);
   tcp_far u_tcp_far (.i_clock, .i_go(go), .o_clk(i_count_clk), .o_edges(edges));
   always #10 i_clock = ~i_clock;
   // hang guard: the run needs well under 2000 cycles
   always @(posedge i_clock)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         mismatches++;
         test_done();
      end
   end
   task automatic chk(input logic ok, input string m);
      checks++;
      if (ok !== 1'b1) begin mismatches++; $display("[FAIL] %0t %s", $time, m); end
   endtask : chk
   task automatic wr(input tcp_sw_s v);
      @(negedge i_clock) i_sw = v;
      @(negedge i_clock) i_sw = '0;
   endtask : wr
   task automatic wirq;
      repeat (200) @(negedge i_clock) if (o_irq === 1'b1) break;
      chk(o_irq === 1'b1 && o_count === o_reload, "no underflow");
      n = edges - e0;
      e0 = edges;
   endtask : wirq
   task automatic t_cont;
      wr('{1'b1, 16'h0002, 1'b1, 16'h0001, 1'b0, 1'b0});
      f = o_inout_timer_channel;
      wr('{1'b0, 16'h0000, 1'b0, 16'h0000, 1'b1, 1'b1});
      chk(o_running === 1'b1 && o_inout_timer_channel === ~f, "start");
      e0 = edges;
      go = 1'h1;
      wirq();
      chk(n === 8'h03, "first phase");
      wirq();
      chk(n === 8'h02, "later phase");
      wr('{1'b0, 16'h0000, 1'b0, 16'h0000, 1'b1, 1'b0});
      f = o_inout_timer_channel;
      repeat (40) @(negedge i_clock);
      chk(!o_running && o_inout_timer_channel === f && o_irq === 1'b0, "stop");
   endtask : t_cont
   task automatic t_ext;
      @(negedge i_clock) i_ext_enable = 1'h1;
      repeat (5) @(negedge i_clock);
      chk(o_running === 1'b1, "ext start");
      wr('{1'b0, 16'h0000, 1'b0, 16'h0000, 1'b1, 1'b0});
      i_ext_enable = 1'h0;
      repeat (2) @(negedge i_clock) i_ext_enable = 1'h1;
      wr('{1'b0, 16'h0000, 1'b0, 16'h0000, 1'b1, 1'b0});
      repeat (6) @(negedge i_clock);
      chk(o_running === 1'b0, "stop beats ext");
   endtask : t_ext
   task automatic test_done;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : test_done
   initial
   begin
      repeat (3) @(negedge i_clock);
      i_resetn = 1'h1;
      t_cont();
      t_ext();
      test_done();
   end
endmodule : tb_tcp_channel
